// ---- src/ppmc_port.sv ----
// Port pin group with alternate and hardware-master output selection
`timescale 1ns/1ns
`default_nettype none
`include "ppmc_cfg.svh"
module ppmc_port
    import ppmc_pkg::*;
#(
    parameter int NUM_PINS = 16,
    parameter int PORT_ID = 0,
    parameter logic [31:0] CHIP_ID = `PPMC_CHIP_ID_DEFAULT,
    parameter logic [31:0] JTAG_ID = `PPMC_JTAG_ID_DEFAULT
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hibReset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PPMC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [NUM_PINS-1:0] pinIn,
    output logic [NUM_PINS-1:0] pinOut,
    output logic [NUM_PINS-1:0] pinOutEn_n,
    output logic [NUM_PINS-1:0] pinPullUp,
    output logic [NUM_PINS-1:0] pinPullDown,
    output logic [2*NUM_PINS-1:0] pinDriveMode,
    // Peripheral side
    input wire logic [4*NUM_PINS-1:0] alternateOutput,
    input wire logic [2*NUM_PINS-1:0] hwMasterOutput,
    input wire logic [2*NUM_PINS-1:0] hwMasterEnable,
    output logic [NUM_PINS-1:0] hwMasterInput,
    output logic [NUM_PINS-1:0] peripheralInput,
    // Hibernate pin
    input wire logic hibPinIn,
    output logic hibPinOut,
    output logic hibPinOutEn_n,
    output logic [1:0] hibDriveMode,
    // Debug mode-select pin
    input wire logic tmsLevel,
    input wire logic tmsEnable,
    output logic tmsPinOut,
    output logic tmsPinOutEn_n,
    output logic tmsPullUp,
    output logic [1:0] tmsDriveMode
);
    if (NUM_PINS < 1 || NUM_PINS > 16)
    begin : g_bad_pins
        $error("NUM_PINS must lie in 1..16");
    end

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] mergeLanes(input logic [31:0] oldValue, input logic [31:0] newValue,
                                               input logic [3:0] strobe);
        logic [31:0] merged;
        merged = oldValue;
        for (int b = 0; b < 4; b++)
        begin
            if (strobe[b])
            begin
                merged[8*b +: 8] = newValue[8*b +: 8];
            end
        end
        return merged;
    endfunction

    // Mask of bits that belong to implemented pins, for a given field width
    function automatic logic [31:0] pinMask(input int fieldWidth);
        logic [31:0] mask;
        mask = 32'h0000_0000;
        for (int p = 0; p < NUM_PINS; p++)
        begin
            for (int f = 0; f < fieldWidth; f++)
            begin
                if (p * fieldWidth + f < 32)
                begin
                    mask[p * fieldWidth + f] = 1'b1;
                end
            end
        end
        return mask;
    endfunction

    // Hardware-master reset values: debug pins start owned by master 0
    function automatic logic [31:0] hwselReset(input int portId);
        logic [31:0] value;
        value = 32'h0000_0000;
        if (portId == `PPMC_DBG_PORT_A)
        begin
            value[`PPMC_TDI_PIN * `PPMC_HWSEL_W +: `PPMC_HWSEL_W] = PPMC_HW_MASTER0;
            value[`PPMC_TRST_PIN * `PPMC_HWSEL_W +: `PPMC_HWSEL_W] = PPMC_HW_MASTER0;
        end
        if (portId == `PPMC_DBG_PORT_B)
        begin
            value[`PPMC_TDO_PIN * `PPMC_HWSEL_W +: `PPMC_HWSEL_W] = PPMC_HW_MASTER0;
        end
        return value & pinMask(`PPMC_HWSEL_W);
    endfunction

    // Pull reset values: only the debug test reset pin pulls down
    function automatic logic [31:0] pullReset(input int portId);
        logic [31:0] value;
        value = 32'h0000_0000;
        if (portId == `PPMC_DBG_PORT_A)
        begin
            value[`PPMC_TRST_PIN * `PPMC_PULL_W +: `PPMC_PULL_W] = PPMC_PULL_DOWN;
        end
        return value & pinMask(`PPMC_PULL_W);
    endfunction

    localparam logic [31:0] HWSEL_RESET = hwselReset(PORT_ID);
    localparam logic [31:0] PULL_RESET = pullReset(PORT_ID);
    localparam logic [31:0] BIT_MASK = pinMask(1);
    localparam logic [31:0] FSEL_MASK0 = pinMask(`PPMC_FSEL_W);
    // Upper field word only covers pins eight and above
    localparam logic [31:0] FSEL_MASK1 = NUM_PINS > 8 ?
        32'((64'h1 << (`PPMC_FSEL_W * (NUM_PINS - 8))) - 64'h1) : 32'h0000_0000;
    localparam logic [31:0] PAIR_MASK = pinMask(2);
    localparam logic [31:0] HIB_MASK = 32'h0000_0037;

    logic [31:0] port_output_level;
    logic [31:0] port_input_level;
    logic [31:0] fsel0;
    logic [31:0] fsel1;
    logic [31:0] hw_master_select;
    logic [31:0] pullSelect;
    logic [31:0] driveSelect;
    logic [31:0] hibControl;

    // Bus decode
    wire [`PPMC_NUM_REGS-1:0] regSel;
    wire regHit;

    ppmc_reg_decode u_decode
    (
        .paddr(paddr),
        .regSel(regSel),
        .regHit(regHit)
    );

    wire setupPhase = psel && !penable;
    wire writeNow = psel && penable && pwrite && regHit;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !regHit;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port_input_level <= 32'h0000_0000;
        end
        else
        begin
            port_input_level <= {{(32-NUM_PINS){1'b0}}, pinIn};
        end
    end

    assign peripheralInput = port_input_level[NUM_PINS-1:0];
    assign hwMasterInput = port_input_level[NUM_PINS-1:0];

    // Register writes
    // plain input, no pull after reset
    // test reset owns pin with pull-down
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port_output_level <= 32'h0000_0000;
            fsel0 <= 32'h0000_0000;
            fsel1 <= 32'h0000_0000;
            hw_master_select <= HWSEL_RESET;
            pullSelect <= PULL_RESET;
            driveSelect <= 32'h0000_0000;
        end
        else if (writeNow)
        begin
            if (regSel[`PPMC_IDX_OUT])
            begin
                port_output_level <= mergeLanes(port_output_level, pwdata, pstrb) & BIT_MASK;
            end
            if (regSel[`PPMC_IDX_FSEL0])
            begin
                fsel0 <= mergeLanes(fsel0, pwdata, pstrb) & FSEL_MASK0;
            end
            if (regSel[`PPMC_IDX_FSEL1])
            begin
                fsel1 <= mergeLanes(fsel1, pwdata, pstrb) & FSEL_MASK1;
            end
            if (regSel[`PPMC_IDX_HWSEL])
            begin
                hw_master_select <= mergeLanes(hw_master_select, pwdata, pstrb) & PAIR_MASK;
            end
            if (regSel[`PPMC_IDX_PULL])
            begin
                pullSelect <= mergeLanes(pullSelect, pwdata, pstrb) & PAIR_MASK;
            end
            if (regSel[`PPMC_IDX_DRIVE])
            begin
                driveSelect <= mergeLanes(driveSelect, pwdata, pstrb) & PAIR_MASK;
            end
        end
    end

    // hibernate pin open-drain low, medium mode
    always_ff @(posedge mclk or negedge hibReset_n)
    begin
        if (!hibReset_n)
        begin
            hibControl <= `PPMC_HIB_RESET;
        end
        else if (writeNow && regSel[`PPMC_IDX_HIB])
        begin
            hibControl <= mergeLanes(hibControl, pwdata, pstrb) & HIB_MASK;
        end
    end

    // Read mux
    wire [63:0] fselAll = {fsel1, fsel0};
    wire [31:0] hibStatus = {25'h0, hibPinIn, hibControl[5:0]};
    wire [31:0] readMux =
        regSel[`PPMC_IDX_OUT] ? port_output_level :
        regSel[`PPMC_IDX_IN] ? port_input_level :
        regSel[`PPMC_IDX_FSEL0] ? fsel0 :
        regSel[`PPMC_IDX_FSEL1] ? fsel1 :
        regSel[`PPMC_IDX_HWSEL] ? hw_master_select :
        regSel[`PPMC_IDX_PULL] ? pullSelect :
        regSel[`PPMC_IDX_DRIVE] ? driveSelect :
        regSel[`PPMC_IDX_HIB] ? hibStatus :
        regSel[`PPMC_IDX_CHIPID] ? CHIP_ID :
        regSel[`PPMC_IDX_JTAGID] ? JTAG_ID : 32'h0000_0000;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setupPhase)
        begin
            prdata <= pwrite ? 32'h0000_0000 : readMux;
        end
    end

    // Per-pin output selection
    logic [NUM_PINS-1:0] next_pinOut;
    logic [NUM_PINS-1:0] next_pinOutEn_n;
    logic [2*NUM_PINS-1:0] next_pinDriveMode;

    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_pin
        wire [`PPMC_FSEL_W-1:0] field = fselAll[i * `PPMC_FSEL_W +: `PPMC_FSEL_W];
        wire muxLevel;
        wire muxDrive;
        wire muxOpenDrain;

        ppmc_pin_mux u_mux
        (
            .mode(field[2:0]),
            .openDrain(field[`PPMC_FSEL_OD_BIT]),
            .driveCode(driveSelect[2*i +: 2]),
            .hwSelect(hw_master_select[2*i +: 2]),
            .gpioLevel(port_output_level[i]),
            .altLevel(alternateOutput[4*i +: 4]),
            .hwLevel(hwMasterOutput[2*i +: 2]),
            .hwEnable(hwMasterEnable[2*i +: 2]),
            .muxLevel(muxLevel),
            .muxDrive(muxDrive),
            .muxOpenDrain(muxOpenDrain),
            .muxDriveCode(next_pinDriveMode[2*i +: 2])
        );

        // Open drain only sinks, releasing the pad for a one
        assign next_pinOut[i] = muxLevel;
        assign next_pinOutEn_n[i] = !(muxDrive && (!muxOpenDrain || !muxLevel));
    end

    wire hibDrive = hibControl[`PPMC_HIB_EN_BIT] &&
                    (!hibControl[`PPMC_HIB_OD_BIT] || !hibControl[`PPMC_HIB_LEVEL_BIT]);

    // Pad outputs from flops
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinOut <= '0;
            pinOutEn_n <= '1;
            pinDriveMode <= '0;
            pinPullUp <= '0;
            pinPullDown <= '0;
            tmsPinOut <= 1'b0;
            tmsPinOutEn_n <= 1'b1;
        end
        else
        begin
            pinOut <= next_pinOut;
            pinOutEn_n <= next_pinOutEn_n;
            pinDriveMode <= next_pinDriveMode;
            for (int p = 0; p < NUM_PINS; p++)
            begin
                pinPullUp[p] <= pullSelect[2*p +: 2] == PPMC_PULL_UP;
                pinPullDown[p] <= pullSelect[2*p +: 2] == PPMC_PULL_DOWN;
            end
            tmsPinOut <= tmsLevel;
            tmsPinOutEn_n <= !tmsEnable;
        end
    end

    // hibernate pad follows its own reset
    assign hibPinOut = hibControl[`PPMC_HIB_LEVEL_BIT];
    assign hibPinOutEn_n = !hibDrive;
    assign hibDriveMode = hibControl[`PPMC_HIB_DRV_LSB +: 2];

    assign tmsPullUp = 1'b1;
    assign tmsDriveMode = PPMC_DRV_STRONG_SOFT;
endmodule
`default_nettype wire

// ---- src/ppmc_cfg.svh ----
// Offsets, field codes, reset values and identity values of the port block
`ifndef PPMC_CFG_SVH
`define PPMC_CFG_SVH

// Register indices; byte address is four times the index
`define PPMC_NUM_REGS 10
`define PPMC_IDX_OUT 0
`define PPMC_IDX_IN 1
`define PPMC_IDX_FSEL0 2
`define PPMC_IDX_FSEL1 3
`define PPMC_IDX_HWSEL 4
`define PPMC_IDX_PULL 5
`define PPMC_IDX_DRIVE 6
`define PPMC_IDX_HIB 7
`define PPMC_IDX_CHIPID 8
`define PPMC_IDX_JTAGID 9
`define PPMC_ADDR_W 12

// Per-pin field widths
`define PPMC_FSEL_W 4
`define PPMC_FSEL_OD_BIT 3
`define PPMC_HWSEL_W 2
`define PPMC_PULL_W 2
`define PPMC_DRV_W 2

// Hibernate control fields
`define PPMC_HIB_LEVEL_BIT 0
`define PPMC_HIB_OD_BIT 1
`define PPMC_HIB_EN_BIT 2
`define PPMC_HIB_DRV_LSB 4
`define PPMC_HIB_RESET 32'h0000_0016

// Special pins handed to the debugger after reset
`define PPMC_DBG_PORT_A 0
`define PPMC_TDI_PIN 7
`define PPMC_TRST_PIN 8
`define PPMC_DBG_PORT_B 2
`define PPMC_TDO_PIN 1

// Identity values, arbitrary
`define PPMC_CHIP_ID_DEFAULT 32'h0000_1001
`define PPMC_JTAG_ID_DEFAULT 32'h1000_0001

`endif

// ---- src/ppmc_pkg.sv ----
// Types of the port pin multiplexer block
package ppmc_pkg;
    typedef enum logic [2:0]
    {
        PPMC_MODE_INPUT = 3'h0,
        PPMC_MODE_GPIO = 3'h1,
        PPMC_MODE_ALTERNATE_OUTPUT_ONE = 3'h2,
        PPMC_MODE_ALT2 = 3'h3,
        PPMC_MODE_ALT3 = 3'h4,
        PPMC_MODE_ALT4 = 3'h5
    } ppmc_mode_type;

    typedef enum logic [1:0]
    {
        PPMC_HW_NONE = 2'h0,
        PPMC_HW_MASTER0 = 2'h1,
        PPMC_HW_MASTER1 = 2'h2
    } ppmc_hwsel_type;

    typedef enum logic [1:0]
    {
        PPMC_PULL_NONE = 2'h0,
        PPMC_PULL_DOWN = 2'h1,
        PPMC_PULL_UP = 2'h2
    } ppmc_pull_type;

    typedef enum logic [1:0]
    {
        PPMC_DRV_STRONG = 2'h0,
        PPMC_DRV_MEDIUM = 2'h1,
        PPMC_DRV_STRONG_SOFT = 2'h2,
        PPMC_DRV_WEAK = 2'h3
    } ppmc_drive_type;
endpackage

// ---- src/ppmc_reg_decode.sv ----
// Address decode of the port register window
`timescale 1ns/1ns
`default_nettype none
`include "ppmc_cfg.svh"
module ppmc_reg_decode
    import ppmc_pkg::*;
(
    input wire logic [`PPMC_ADDR_W-1:0] paddr,
    output logic [`PPMC_NUM_REGS-1:0] regSel,
    output logic regHit
);
    wire aligned = (paddr[1:0] == 2'h0);
    wire [`PPMC_ADDR_W-3:0] wordIdx = paddr[`PPMC_ADDR_W-1:2];

    for (genvar i = 0; i < `PPMC_NUM_REGS; i++)
    begin : g_sel
        assign regSel[i] = aligned && (wordIdx == (`PPMC_ADDR_W-2)'(i));
    end

    assign regHit = |regSel;
endmodule
`default_nettype wire

// ---- src/ppmc_pin_mux.sv ----
// Output source selection for a single port pin
`timescale 1ns/1ns
`default_nettype none
module ppmc_pin_mux
    import ppmc_pkg::*;
(
    input wire logic [2:0] mode,
    input wire logic openDrain,
    input wire logic [1:0] driveCode,
    input wire logic [1:0] hwSelect,
    input wire logic gpioLevel,
    input wire logic [3:0] altLevel,
    input wire logic [1:0] hwLevel,
    input wire logic [1:0] hwEnable,
    output logic muxLevel,
    output logic muxDrive,
    output logic muxOpenDrain,
    output logic [1:0] muxDriveCode
);
    logic swLevel;
    logic swDrive;

    // Software path: input, port bit or alternate peripheral
    always_comb
    begin
        swLevel = 1'b0;
        swDrive = 1'b1;
        unique case (mode)
            PPMC_MODE_INPUT: swDrive = 1'b0;
            PPMC_MODE_GPIO: swLevel = gpioLevel;
            PPMC_MODE_ALTERNATE_OUTPUT_ONE: swLevel = altLevel[0];
            PPMC_MODE_ALT2: swLevel = altLevel[1];
            PPMC_MODE_ALT3: swLevel = altLevel[2];
            PPMC_MODE_ALT4: swLevel = altLevel[3];
            default: swDrive = 1'b0;
        endcase
    end

    wire hwOwned = (hwSelect == PPMC_HW_MASTER0) || (hwSelect == PPMC_HW_MASTER1);
    wire hwIdx = (hwSelect == PPMC_HW_MASTER1);

    // Hardware master takes level, enable and pad mode
    assign muxLevel = hwOwned ? hwLevel[hwIdx] : swLevel;
    assign muxDrive = hwOwned ? hwEnable[hwIdx] : swDrive;
    assign muxOpenDrain = hwOwned ? 1'b0 : openDrain;
    assign muxDriveCode = hwOwned ? PPMC_DRV_STRONG : driveCode;
endmodule
`default_nettype wire

// ---- verification/ppmc_port_checker.sv ----
// Concurrent checks on the bus, pad and debug ports of the port block
`timescale 1ns/1ns
`default_nettype none
`include "ppmc_cfg.svh"
module ppmc_port_checker
#(
    parameter int NUM_PINS = 16,
    parameter logic [31:0] CHIP_ID = 32'h0,
    parameter logic [31:0] JTAG_ID = 32'h0
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hibReset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PPMC_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_PINS-1:0] pinIn,
    input wire logic [NUM_PINS-1:0] pinOut,
    input wire logic [NUM_PINS-1:0] pinOutEn_n,
    input wire logic [NUM_PINS-1:0] pinPullUp,
    input wire logic [NUM_PINS-1:0] pinPullDown,
    input wire logic [2*NUM_PINS-1:0] hwMasterOutput,
    input wire logic [2*NUM_PINS-1:0] hwMasterEnable,
    input wire logic [NUM_PINS-1:0] hwMasterInput,
    input wire logic [NUM_PINS-1:0] peripheralInput,
    input wire logic hibPinOut,
    input wire logic hibPinOutEn_n,
    input wire logic [1:0] hibDriveMode,
    input wire logic tmsLevel,
    input wire logic tmsEnable,
    input wire logic tmsPinOut,
    input wire logic tmsPinOutEn_n,
    input wire logic tmsPullUp,
    input wire logic [1:0] tmsDriveMode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence chipSetup;
        psel && !penable && !pwrite && paddr == 4 * `PPMC_IDX_CHIPID;
    endsequence
    sequence jtagSetup;
        psel && !penable && !pwrite && paddr == 4 * `PPMC_IDX_JTAGID;
    endsequence
    sequence firstRun;
        $rose(reset_n);
    endsequence

    pready_high_a: assert property (pready)
        else $error("pready low");
    bus_error_a: assert property (
        psel && penable |-> pslverr == (paddr > 4 * `PPMC_IDX_JTAGID || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    input_copy_a: assert property (
        $past(reset_n) |-> peripheralInput == $past(pinIn) && hwMasterInput == $past(pinIn))
        else $error("input copy wrong");
    hw_handover_a: assert property (
        firstRun |=> pinOut[7] == $past(hwMasterOutput[14]) && pinOutEn_n[7] == !$past(hwMasterEnable[14])
            && pinOut[8] == $past(hwMasterOutput[16]) && pinOutEn_n[8] == !$past(hwMasterEnable[16])
            && pinPullDown[8])
        else $error("debug pins not handed over");
    reset_defaults_a: assert property (
        firstRun |=> &pinOutEn_n[6:0] && &pinOutEn_n[NUM_PINS-1:9] && pinPullUp == '0
            && pinPullDown[7:0] == 8'h0 && pinPullDown[NUM_PINS-1:9] == '0)
        else $error("pins not plain inputs after reset");
    hib_reset_a: assert property (
        !hibReset_n |-> !hibPinOut && !hibPinOutEn_n && hibDriveMode == 2'h1)
        else $error("hibernate pin not reset");
    tms_pad_a: assert property (tmsPullUp && tmsDriveMode == 2'h2)
        else $error("mode-select pad setup wrong");
    tms_follow_a: assert property (
        $past(reset_n) |-> tmsPinOut == $past(tmsLevel) && tmsPinOutEn_n == !$past(tmsEnable))
        else $error("mode-select pin does not follow");
    chip_read_a: assert property (chipSetup |=> prdata == CHIP_ID)
        else $error("chip id read wrong");
    jtag_read_a: assert property (jtagSetup ##1 1'b1 |-> prdata == JTAG_ID)
        else $error("jtag id read wrong");
endmodule

bind ppmc_port ppmc_port_checker #(.NUM_PINS(NUM_PINS), .CHIP_ID(CHIP_ID), .JTAG_ID(JTAG_ID)) checker_inst (
    .mclk, .reset_n, .hibReset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .pinIn, .pinOut, .pinOutEn_n, .pinPullUp, .pinPullDown, .hwMasterOutput, .hwMasterEnable,
    .hwMasterInput, .peripheralInput, .hibPinOut, .hibPinOutEn_n, .hibDriveMode,
    .tmsLevel, .tmsEnable, .tmsPinOut, .tmsPinOutEn_n, .tmsPullUp, .tmsDriveMode
);
`default_nettype wire

// ---- verification/ppmc_pad_model.sv ----
// Board side of the pads: resolves each pin from drivers and pulls
`timescale 1ns/1ns
`default_nettype none
module ppmc_pad_model
#(
    parameter int NUM_PINS = 16
)
(
    input wire logic mclk,
    input wire logic [NUM_PINS-1:0] pinOut,
    input wire logic [NUM_PINS-1:0] pinOutEn_n,
    input wire logic [NUM_PINS-1:0] pinPullUp,
    input wire logic [NUM_PINS-1:0] pinPullDown,
    input wire logic hibPinOut,
    input wire logic hibPinOutEn_n,
    output logic [NUM_PINS-1:0] pinIn,
    output logic hibPinIn
);
    logic [NUM_PINS-1:0] floatLevel = '0;

    // Released pins with no pull wander every cycle
    always @(posedge mclk)
    begin
        floatLevel <= ~floatLevel;
    end

    always_comb
    begin
        for (int i = 0; i < NUM_PINS; i++)
            pinIn[i] = !pinOutEn_n[i] ? pinOut[i] : pinPullUp[i] ? 1'b1 : pinPullDown[i] ? 1'b0 : floatLevel[i];
    end

    assign hibPinIn = hibPinOutEn_n ? floatLevel[0] : hibPinOut;
endmodule
`default_nettype wire

// ---- verification/port_pin_mux_control_bench.sv ----
// Self-checking bench of the port block
`timescale 1ns/1ns
`default_nettype none
`include "ppmc_cfg.svh"
module port_pin_mux_control_bench;
    localparam logic [31:0] RESET_VALUE [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0001_4000, 32'h0001_0000,
        32'h0, 32'h16, `PPMC_CHIP_ID_DEFAULT, `PPMC_JTAG_ID_DEFAULT};
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic hibReset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [63:0] altOut = '0;
    logic [31:0] hwOut = '0;
    logic [31:0] hwEn = '0;
    logic tmsLevel = 1'b0;
    logic tmsEnable = 1'b0;
    logic [31:0] prdata, rd, driveMode;
    logic pready, pslverr, err, hibPinIn, hibPinOut, hibOe_n, tmsOut, tmsOe_n, tmsPull;
    logic [15:0] pinIn, pinOut, pinOutEn_n, pinPullUp, pinPullDown, hwIn, perIn;
    logic [1:0] hibDrive, tmsDrive;
    int badCount = 0;
    int checks = 0;

    ppmc_port #(.NUM_PINS(16), .PORT_ID(0)) uut (
        .mclk(mclk), .reset_n(reset_n), .hibReset_n(hibReset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .pinPullUp(pinPullUp),
        .pinPullDown(pinPullDown), .pinDriveMode(driveMode), .alternateOutput(altOut), .hwMasterOutput(hwOut),
        .hwMasterEnable(hwEn), .hwMasterInput(hwIn), .peripheralInput(perIn), .hibPinIn(hibPinIn),
        .hibPinOut(hibPinOut), .hibPinOutEn_n(hibOe_n), .hibDriveMode(hibDrive), .tmsLevel(tmsLevel),
        .tmsEnable(tmsEnable), .tmsPinOut(tmsOut), .tmsPinOutEn_n(tmsOe_n), .tmsPullUp(tmsPull),
        .tmsDriveMode(tmsDrive)
    );

    ppmc_pad_model #(.NUM_PINS(16)) pads (
        .mclk(mclk), .pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .pinPullUp(pinPullUp),
        .pinPullDown(pinPullDown), .hibPinOut(hibPinOut), .hibPinOutEn_n(hibOe_n), .pinIn(pinIn),
        .hibPinIn(hibPinIn)
    );

    initial
    begin
        forever #4 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] expected, input logic [31:0] seen);
        checks++;
        if (seen !== expected)
        begin
            badCount++;
            $display("ERROR %s expected %h seen %h", what, expected, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        if (n >= 40)
            badCount++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge mclk);
        badCount++;
        give_verdict;
    end

    initial
    begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        hibReset_n <= 1'b1;
        settle(2);
        check("pad enables", 32'hffff, 32'(pinOutEn_n));
        check("pull downs", 32'h0100, 32'({pinPullUp, pinPullDown}));
        check("hibernate pad", 32'h1, 32'({hibPinOut, hibOe_n, hibDrive}));
        check("mode-select pad", 32'h0e, 32'({tmsOut, tmsOe_n, tmsPull, tmsDrive}));
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b0, 12'(4 * i), 32'h0);
            if (i != 1)
                check("reset value", RESET_VALUE[i], rd);
        end
        for (int i = 8; i < 10; i++)
        begin
            apb(1'b1, 12'(4 * i), 32'hffff_ffff);
            apb(1'b0, 12'(4 * i), 32'h0);
            check("identity word", RESET_VALUE[i], rd);
        end
        apb(1'b1, 12'h028, 32'h1);
        check("unmapped write error", 32'h1, 32'(err));
        apb(1'b0, 12'h002, 32'h0);
        check("unaligned read", 32'h0, rd);
        check("unaligned read error", 32'h1, 32'(err));
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h018, 32'h5555);
        apb(1'b1, 12'h00c, 32'h1111_1111);
        apb(1'b1, 12'h000, 32'ha5c3);
        altOut <= {8{8'h5a}};
        for (int m = 0; m < 6; m++)
        begin
            apb(1'b1, 12'h008, {8{4'(m)}});
            settle(2);
            check("pad enables", m == 0 ? 32'h00ff : 32'h0, 32'(pinOutEn_n));
            if (m > 0)
                check("pin levels", {16'h0, 8'ha5, m == 1 ? 8'hc3 : m[0] ? 8'h55 : 8'haa}, 32'(pinOut));
            if (m > 1)
                check("drive codes", 32'h5555, driveMode);
            if (m == 1)
            begin
                apb(1'b0, 12'h004, 32'h0);
                check("input register", 32'ha5c3, rd);
            end
        end
        apb(1'b1, 12'h008, {8{4'h9}});
        settle(2);
        check("open-drain enables", 32'h00c3, 32'(pinOutEn_n));
        apb(1'b1, 12'h010, 32'haaaa);
        hwOut <= 32'haaaa;
        hwEn <= 32'haaaa;
        settle(2);
        check("master levels", 32'ha5ff, 32'(pinOut));
        check("master enables", 32'h0, 32'(pinOutEn_n));
        check("master drive", 32'h0, driveMode);
        check("peripheral inputs", 32'ha5ff_a5ff, 32'({hwIn, perIn}));
        @(posedge mclk);
        hwEn <= 32'h0;
        settle(2);
        check("master released", 32'h00ff, 32'(pinOutEn_n));
        apb(1'b1, 12'h014, 32'h0001_0002);
        settle(2);
        check("pull ups", 32'h0001_0100, 32'({pinPullUp, pinPullDown}));
        apb(1'b1, 12'h01c, 32'h5);
        settle(2);
        check("hibernate driven", 32'h8, 32'({hibPinOut, hibOe_n, hibDrive}));
        @(posedge mclk);
        hibReset_n <= 1'b0;
        settle(1);
        check("hibernate reset", 32'h1, 32'({hibPinOut, hibOe_n, hibDrive}));
        @(posedge mclk);
        hibReset_n <= 1'b1;
        tmsLevel <= 1'b1;
        tmsEnable <= 1'b1;
        apb(1'b0, 12'h01c, 32'h0);
        check("hibernate register", 32'h16, rd);
        settle(1);
        check("mode-select drive", 32'h16, 32'({tmsOut, tmsOe_n, tmsPull, tmsDrive}));
        give_verdict;
    end
endmodule
`default_nettype wire
